// File: rtl/cam_pkg.sv
package cam_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_LINES    = 8'h04;
  localparam logic [7:0]  REG_CMD      = 8'h08;
  localparam logic [7:0]  REG_ROI_X    = 8'h0C;
  localparam logic [7:0]  REG_ROI_Y    = 8'h10;
  localparam logic [7:0]  REG_COUNTS   = 8'h14;
  localparam logic [7:0]  REG_STATUS   = 8'h18;
  localparam logic [7:0]  REG_TAB_ADDR = 8'h1C;
  localparam logic [7:0]  REG_TAB_DATA = 8'h20;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MEM_BIT   = 2;
  localparam int CTRL_MAP_BIT   = 3;
  localparam int CTRL_OUT10_BIT = 4;
  localparam int CTRL_CORR_BIT  = 5;
  localparam int CMD_TRIG_BIT   = 0;
  localparam int CMD_READ_BIT   = 1;
  localparam int CMD_CLEAR_BIT  = 2;
  localparam int TAB_SEL_LSB    = 12;
  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] LINES_RST  = 32'h0000_0000;
  localparam logic [31:0] ROI_X_RST  = 32'h0007_0000;
  localparam logic [31:0] ROI_Y_RST  = 32'h0007_0000;
  localparam logic [31:0] COUNTS_RST = 32'h0000_0101;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] MODE_FIFO  = 2'h0;
  localparam logic [1:0] MODE_CIRC  = 2'h1;
  localparam logic [1:0] MODE_SUM   = 2'h2;
  localparam logic [1:0] SEL_PIN    = 2'h0;
  localparam logic [1:0] SEL_SERIAL = 2'h1;
  localparam logic [1:0] SEL_ON     = 2'h2;
  localparam logic [1:0] TAB_OFFSET = 2'h0;
  localparam logic [1:0] TAB_GAIN   = 2'h1;
  localparam logic [1:0] TAB_MAP    = 2'h2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int PIX_W     = 10;
  localparam int GAIN_W    = 8;
  localparam int GAIN_SHIFT = 7;
  localparam int IDX_W     = 6;
  localparam int SLOT_PIX  = 64;
  localparam int MEM_WORDS = 256;
  localparam int MAP_DEPTH = 1024;
  localparam logic [2:0] NSLOT = 3'h4;
  localparam logic [9:0] FULL8  = 10'h0FF;
  localparam logic [9:0] FULL10 = 10'h3FF;
  localparam logic [3:0] PEND_MAX = 4'hF;
  typedef enum logic [1:0] {RD_IDLE, RD_RUN, RD_SWEEP} rd_state_t;
endpackage

// File: rtl/pixel_correct.sv
module pixel_correct
  import cam_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Table load
  input  wire logic             tabWe,
  input  wire logic [1:0]       tabSel,
  input  wire logic [IDX_W-1:0] tabIdx,
  input  wire logic [PIX_W-1:0] tabData,
  // Pixel
  input  wire logic [PIX_W-1:0] pixRaw,
  input  wire logic [IDX_W-1:0] pixIdx,
  input  wire logic             inRoi,
  input  wire logic             corrEn,
  input  wire logic             out10,
  output logic      [PIX_W-1:0] corrected
);
  logic [PIX_W-1:0]  offTab  [SLOT_PIX];
  logic [GAIN_W-1:0] gainTab [SLOT_PIX];
  logic [PIX_W-1:0]  raw;
  logic [PIX_W-1:0]  full;
  logic [PIX_W:0]    diff;
  logic [PIX_W-1:0]  clipped;
  logic [17:0]       prod;
  logic [17:0]       scaled;
  logic [PIX_W-1:0]  cp;

  always_ff @(posedge clk) begin
    if (tabWe && tabSel == TAB_OFFSET) begin
      offTab[tabIdx] <= tabData;
    end
    if (tabWe && tabSel == TAB_GAIN) begin
      gainTab[tabIdx] <= tabData[GAIN_W-1:0];
    end
  end

  // 8-bit output works on the top 8 raw bits and lands back in the top bits
  always_comb begin
    raw       = out10 ? pixRaw : {2'h0, pixRaw[9:2]};
    full      = out10 ? FULL10 : FULL8;
    diff      = {1'b0, raw} - {1'b0, offTab[pixIdx]};
    clipped   = diff[PIX_W] ? '0 : diff[PIX_W-1:0];
    prod      = 18'(clipped * gainTab[pixIdx]);
    scaled    = prod >> GAIN_SHIFT;
    cp        = (scaled >= {8'h00, full}) ? full : scaled[PIX_W-1:0];
    corrected = !(corrEn && inRoi) ? pixRaw : (out10 ? cp : {cp[7:0], 2'h0});
  end
endmodule

// File: rtl/camera_image_memory_pipeline.sv
// Implementation choices: the AXI4-Lite slave port and the register addresses.
module camera_image_memory_pipeline
  import cam_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Sensor pixel stream
  input  wire logic [PIX_W-1:0] pixIn,
  input  wire logic             pixFval,
  input  wire logic             pixLval,
  input  wire logic             pixDval,
  // Control line pins
  input  wire logic             ccTrig,
  input  wire logic             ccRead,
  input  wire logic             ccClear,
  output logic                  trigOut,
  // Output link
  output logic [PIX_W-1:0]      linkData,
  output logic                  linkFval,
  output logic                  linkLval,
  output logic                  linkDval
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]      ctrl, lines, roiX, roiY, counts, tabAddr;
  logic [7:0]       awAddr;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             awGot, wGot, wrFire;
  logic [2:0]       cmdPulse;
  logic [2:0]       syncA, syncB, syncPrev;
  logic [2:0]       rise;
  logic             readEvt, clearEvt, clearAll;
  logic [1:0]       mode;
  logic             memEn, mapEn, out10, sumMode;
  logic             prevFval, prevLval;
  logic [15:0]      colCnt, rowCnt;
  logic             pixValid, inRoi, frameStart, frameEnd;
  logic [IDX_W:0]   roiIdx;
  logic [PIX_W-1:0] corr;
  logic [31:0]      mem [MEM_WORDS];
  logic [PIX_W-1:0] mapTable [MAP_DEPTH];
  logic [IDX_W:0]   slotLen [4];
  logic [2:0]       count;
  logic [1:0]       wSlot, rSlot;
  logic [3:0]       pending;
  logic             accepting, armed, stopped, armTake;
  logic [7:0]       postCnt, sumCnt;
  logic             commit, cInc, cDec, pInc;
  rd_state_t        rdState;
  logic [IDX_W:0]   rdIdx, rdLen;
  logic [1:0]       rdByte;
  logic [7:0]       sweepIdx;
  logic             ingestWe, stall, emit, rdStart, rdFinish, tabWe;
  logic [31:0]      memRd;
  logic [7:0]       sumByte;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic lineEvt(input logic [1:0] sel, input logic edgeIn,
                                   input logic cmd);
    case (sel)
      SEL_PIN:    return edgeIn | cmd;
      SEL_SERIAL: return cmd;
      SEL_ON:     return 1'b1;
      default:    return 1'b0;
    endcase
  endfunction

  function automatic logic [PIX_W-1:0] fmtPix(input logic [PIX_W-1:0] v,
                                              input logic [PIX_W-1:0] m);
    logic [PIX_W-1:0] s;
    s = mapEn ? m : v;
    return out10 ? s : {2'h0, s[9:2]};
  endfunction

  assign mode    = ctrl[CTRL_MODE_LSB +: 2];
  assign memEn   = ctrl[CTRL_MEM_BIT];
  assign mapEn   = ctrl[CTRL_MAP_BIT];
  assign out10   = ctrl[CTRL_OUT10_BIT];
  assign sumMode = (mode == MODE_SUM);

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign wrFire = awGot && wGot && !s_axi_bvalid;
  assign tabWe  = wrFire && awAddr == REG_TAB_DATA;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awGot         <= 1'b0;
      wGot          <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddr        <= 8'h00;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awGot         <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        awGot         <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (!awGot) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wGot         <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        wGot         <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (!wGot) begin
        s_axi_wready <= 1'b1;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr > REG_TAB_DATA || awAddr[1:0] != 2'h0) ? RESP_SLV : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl     <= CTRL_RST;
      lines    <= LINES_RST;
      roiX     <= ROI_X_RST;
      roiY     <= ROI_Y_RST;
      counts   <= COUNTS_RST;
      tabAddr  <= 32'h0000_0000;
      cmdPulse <= 3'h0;
    end else begin
      cmdPulse <= 3'h0;
      if (wrFire) begin
        case (awAddr)
          REG_CTRL:     ctrl    <= merge(ctrl, wData, wStrb);
          REG_LINES:    lines   <= merge(lines, wData, wStrb);
          REG_CMD:      cmdPulse <= wStrb[0] ? wData[2:0] : 3'h0;
          REG_ROI_X:    roiX    <= merge(roiX, wData, wStrb);
          REG_ROI_Y:    roiY    <= merge(roiY, wData, wStrb);
          REG_COUNTS:   counts  <= merge(counts, wData, wStrb);
          REG_TAB_ADDR: tabAddr <= merge(tabAddr, wData, wStrb);
          default:      cmdPulse <= 3'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:     s_axi_rdata <= ctrl;
        REG_LINES:    s_axi_rdata <= lines;
        REG_CMD:      s_axi_rdata <= 32'h0000_0000;
        REG_ROI_X:    s_axi_rdata <= roiX;
        REG_ROI_Y:    s_axi_rdata <= roiY;
        REG_COUNTS:   s_axi_rdata <= counts;
        REG_STATUS:   s_axi_rdata <= {13'h0000, rdLen, rdState, armed, stopped,
                                      pending, 1'b0, count};
        REG_TAB_ADDR: s_axi_rdata <= tabAddr;
        REG_TAB_DATA: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLV;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control lines
  // ----------------------------------------
  // Pins are asynchronous to the pixel clock; the edge detector sees syncB only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA    <= 3'h0;
      syncB    <= 3'h0;
      syncPrev <= 3'h0;
    end else begin
      syncA    <= {ccClear, ccRead, ccTrig};
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end

  assign rise     = syncB & ~syncPrev;
  assign readEvt  = lineEvt(lines[3:2], rise[1], cmdPulse[CMD_READ_BIT]);
  assign clearEvt = lineEvt(lines[5:4], rise[2], cmdPulse[CMD_CLEAR_BIT]);
  assign clearAll = clearEvt && !(mode == MODE_CIRC && !stopped);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigOut <= 1'b0;
    end else begin
      case (lines[1:0])
        SEL_PIN:    trigOut <= syncB[0] | cmdPulse[CMD_TRIG_BIT];
        SEL_SERIAL: trigOut <= cmdPulse[CMD_TRIG_BIT];
        SEL_ON:     trigOut <= 1'b1;
        default:    trigOut <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Pixel position and correction
  // ----------------------------------------
  assign pixValid   = pixFval && pixLval && pixDval;
  assign frameStart = pixFval && !prevFval;
  assign frameEnd   = prevFval && !pixFval;
  assign inRoi      = pixValid && colCnt >= roiX[15:0] && colCnt <= roiX[31:16]
                      && rowCnt >= roiY[15:0] && rowCnt <= roiY[31:16];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevFval <= 1'b0;
      prevLval <= 1'b0;
      colCnt   <= 16'h0000;
      rowCnt   <= 16'h0000;
      roiIdx   <= '0;
    end else begin
      prevFval <= pixFval;
      prevLval <= pixLval;
      colCnt   <= !pixLval ? 16'h0000 : (pixDval ? colCnt + 16'h0001 : colCnt);
      if (!pixFval) begin
        rowCnt <= 16'h0000;
      end else if (prevLval && !pixLval) begin
        rowCnt <= rowCnt + 16'h0001;
      end
      if (!pixFval) begin
        roiIdx <= '0;
      end else if (inRoi && roiIdx != (IDX_W+1)'(SLOT_PIX)) begin
        roiIdx <= roiIdx + 1'b1;
      end
    end
  end

  pixel_correct u_correct (
    .clk       (clk),
    .tabWe     (tabWe),
    .tabSel    (tabAddr[TAB_SEL_LSB +: 2]),
    .tabIdx    (tabAddr[IDX_W-1:0]),
    .tabData   (wData[PIX_W-1:0]),
    .pixRaw    (pixIn),
    .pixIdx    (roiIdx[IDX_W-1:0]),
    .inRoi     (inRoi),
    .corrEn    (ctrl[CTRL_CORR_BIT]),
    .out10     (out10),
    .corrected (corr)
  );

  always_ff @(posedge clk) begin
    if (tabWe && tabAddr[TAB_SEL_LSB +: 2] == TAB_MAP) begin
      mapTable[tabAddr[9:0]] <= wData[PIX_W-1:0];
    end
  end

  // ----------------------------------------
  // Frame memory bookkeeping
  // ----------------------------------------
  assign armTake = readEvt && mode == MODE_CIRC && !armed;
  assign commit  = frameEnd && accepting && !(mode == MODE_CIRC && stopped);
  assign cInc    = commit && (mode == MODE_FIFO || (mode == MODE_CIRC && count != NSLOT)
                   || (sumMode && sumCnt >= counts[15:8]));
  assign cDec    = rdFinish;
  assign pInc    = readEvt && !armTake && pending != PEND_MAX;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count     <= 3'h0;
      wSlot     <= 2'h0;
      rSlot     <= 2'h0;
      pending   <= 4'h0;
      accepting <= 1'b0;
      armed     <= 1'b0;
      stopped   <= 1'b0;
      postCnt   <= 8'h00;
      sumCnt    <= 8'h00;
    end else if (clearAll) begin
      count     <= 3'h0;
      wSlot     <= 2'h0;
      rSlot     <= 2'h0;
      pending   <= 4'h0;
      accepting <= 1'b0;
      armed     <= 1'b0;
      stopped   <= 1'b0;
      sumCnt    <= 8'h00;
    end else begin
      if (clearEvt) begin
        stopped <= 1'b1;
      end
      if (frameStart) begin
        accepting <= memEn && rdState != RD_SWEEP
                     && (mode == MODE_CIRC ? !stopped : count != NSLOT);
      end else if (frameEnd) begin
        accepting <= 1'b0;
      end
      if (armTake) begin
        armed   <= 1'b1;
        postCnt <= counts[7:0];
        if (counts[7:0] == 8'h00) begin
          stopped <= 1'b1;
        end
      end
      if (commit) begin
        slotLen[wSlot] <= roiIdx;
        if (mode == MODE_CIRC) begin
          wSlot <= wSlot + 2'h1;
          if (count == NSLOT) begin
            rSlot <= rSlot + 2'h1;
          end
          if (armed && postCnt != 8'h00) begin
            postCnt <= postCnt - 8'h01;
            stopped <= (postCnt == 8'h01);
          end
        end else if (cInc) begin
          wSlot  <= wSlot + 2'h1;
          sumCnt <= 8'h00;
        end else begin
          sumCnt <= sumCnt + 8'h01;
        end
      end
      if (rdFinish) begin
        rSlot <= rSlot + 2'h1;
      end
      count   <= count + {2'h0, cInc} - {2'h0, cDec};
      pending <= pending + {3'h0, pInc} - {3'h0, rdStart};
    end
  end

  // ----------------------------------------
  // Memory array
  // ----------------------------------------
  assign ingestWe = accepting && inRoi && roiIdx != (IDX_W+1)'(SLOT_PIX)
                    && !(mode == MODE_CIRC && stopped);
  assign memRd    = mem[{rSlot, rdIdx[IDX_W-1:0]}];
  assign stall    = sumMode && ingestWe;
  assign sumByte  = 8'(memRd >> {rdByte, 3'h0});

  // Ingest owns the write port; summing readout waits a cycle on a clash
  always_ff @(posedge clk) begin
    if (rdState == RD_SWEEP) begin
      mem[sweepIdx] <= 32'h0000_0000;
    end else if (ingestWe) begin
      mem[{wSlot, roiIdx[IDX_W-1:0]}] <= sumMode
        ? mem[{wSlot, roiIdx[IDX_W-1:0]}] + {22'h000000, corr}
        : {22'h000000, corr};
    end else if (emit && sumMode && rdByte == 2'h3) begin
      mem[{rSlot, rdIdx[IDX_W-1:0]}] <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Readout engine
  // ----------------------------------------
  assign rdLen    = slotLen[rSlot];
  assign rdStart  = rdState == RD_IDLE && !clearAll && pending != 4'h0 && count != 3'h0
                    && memEn && (mode != MODE_CIRC || stopped);
  assign rdFinish = rdState == RD_RUN && rdIdx == rdLen && !clearAll;
  assign emit     = rdState == RD_RUN && rdIdx != rdLen && !stall && !clearAll;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdState  <= RD_SWEEP;
      sweepIdx <= 8'h00;
      rdIdx    <= '0;
      rdByte   <= 2'h0;
    end else begin
      case (rdState)
        RD_IDLE: begin
          if (clearAll && sumMode) begin
            rdState  <= RD_SWEEP;
            sweepIdx <= 8'h00;
          end else if (rdStart) begin
            rdState <= RD_RUN;
            rdIdx   <= '0;
            rdByte  <= 2'h0;
          end
        end
        RD_RUN: begin
          if (clearAll) begin
            rdState  <= sumMode ? RD_SWEEP : RD_IDLE;
            sweepIdx <= 8'h00;
          end else if (rdFinish) begin
            rdState <= RD_IDLE;
          end else if (emit) begin
            rdByte <= sumMode ? rdByte + 2'h1 : 2'h0;
            if (!sumMode || rdByte == 2'h3) begin
              rdIdx <= rdIdx + 1'b1;
            end
          end
        end
        RD_SWEEP: begin
          sweepIdx <= sweepIdx + 8'h01;
          if (sweepIdx == 8'(MEM_WORDS - 1)) begin
            rdState <= RD_IDLE;
          end
        end
        default: rdState <= RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Output link
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      linkData <= '0;
      linkFval <= 1'b0;
      linkLval <= 1'b0;
      linkDval <= 1'b0;
    end else if (memEn) begin
      linkFval <= rdState == RD_RUN;
      linkLval <= emit;
      linkDval <= emit;
      linkData <= sumMode ? {2'h0, sumByte}
                          : fmtPix(memRd[PIX_W-1:0], mapTable[memRd[PIX_W-1:0]]);
    end else begin
      linkFval <= pixFval;
      linkLval <= pixLval;
      linkDval <= pixDval;
      linkData <= fmtPix(corr, mapTable[corr]);
    end
  end
endmodule

// File: verif/pipe_props.sv
module pipe_props (
  // Watched ports
  input wire logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic        linkFval, linkLval, linkDval,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid) else $error("late bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
  a_ready_release: assert property ($rose(rst_n) |=> s_axi_awready && s_axi_arready)
    else $error("not ready after reset");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_line_in_frame: assert property (linkLval |-> linkFval)
    else $error("line outside frame");
  a_data_in_line: assert property (linkDval |-> linkLval)
    else $error("data outside line");
endmodule
bind camera_image_memory_pipeline pipe_props u_props (.*);

// File: verif/link_host.sv
module link_host
  import cam_pkg::*;
(
  // Link
  input wire logic             clk, linkFval, linkLval, linkDval,
  input wire logic [PIX_W-1:0] linkData,
  // Capture
  output int                   count,
  output logic     [PIX_W-1:0] first, last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen = 1'h0;
  initial count = 0;
  // Words only count with all three qualifiers high
  always @(posedge clk) begin
    seen <= linkFval & (seen | linkLval & linkDval);
    if (linkFval && linkLval && linkDval) begin
      if (!seen) first <= linkData;
      last <= linkData;
      count <= count + 1;
    end
  end
endmodule

// File: verif/testbench.sv
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module testbench
  import cam_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, pixFval = 0, pixLval = 0, pixDval = 0;
  logic ccTrig = 0, ccRead = 0, ccClear = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, trigOut, linkFval, linkLval, linkDval;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [9:0] pixIn = 0, linkData, first, last;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int errors = 0, testsRun = 0, count, n, d, e, n0;
  int raw[4] = '{500, 50, 1000, 600}, off[4] = '{100, 100, 0, 100};
  int gn[4] = '{128, 200, 255, 255};
  camera_image_memory_pipeline dut (.*);
  link_host host (.*);
  initial forever #10 clk = ~clk;
  // ----------------------------------------
  // Bus and stream tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 99 && !s_axi_bvalid; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    if (n == 99) errors++;
    if (n == 99) tally_and_finish;
    s_axi_bready <= 1'h0;
    // One idle edge keeps the next call from seeing this answer as its own
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 99 && !s_axi_rvalid; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    if (n == 99) errors++;
    if (n == 99) tally_and_finish;
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask
  // Held for several cycles so a repeated edge would show up
  task automatic pulse_read;
    ccRead <= 1'h1;
    repeat (6) @(posedge clk);
    ccRead <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic frame(input int rows, cols, input logic [9:0] base);
    pixFval <= 1'h1;
    for (int r = 0; r < rows; r++) begin
      for (int c = 0; c < cols; c++) begin
        @(posedge clk);
        {pixLval, pixDval, pixIn} <= {2'h3, 10'(base + r * 8 + c)};
      end
      @(posedge clk);
      {pixLval, pixDval} <= 2'h0;
      repeat (2) @(posedge clk);
    end
    pixFval <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // Extra idle time lets a wrongly stored frame show up
  task automatic drain(input int want);
    for (int i = 0; i < 3000 && count < want; i++) @(posedge clk);
    repeat (200) @(posedge clk);
    `CHK(count, want)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (300) @(posedge clk);
    rd(REG_COUNTS); `CHK(rdat, COUNTS_RST)
    rd(REG_ROI_X); `CHK(rdat, ROI_X_RST)
    rd(8'h40); `CHK({resp, rdat}, {RESP_SLV, 32'h0})
    ccTrig <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK(trigOut, 1'h1)
    wr(REG_LINES, 32'h3);
    `CHK(trigOut, 1'h0)
    wr(REG_CTRL, 32'h30);
    for (int k = 0; k < 4; k++) begin
      wr(REG_TAB_ADDR, 32'h0);
      wr(REG_TAB_DATA, off[k]);
      wr(REG_TAB_ADDR, 32'h1000);
      wr(REG_TAB_DATA, gn[k]);
      frame(1, 1, 10'(raw[k]));
      d = raw[k] > off[k] ? raw[k] - off[k] : 0;
      e = 2 * gn[k] * d / 256;
      `CHK(last, 10'(e >= 1023 ? 1023 : e))
    end
    frame(1, 9, 10'h200); `CHK(last, 10'h208)
    wr(REG_CTRL, 32'h14);
    n0 = count;
    wr(REG_CMD, 32'h2);
    frame(8, 8, 10'h40);
    drain(n0 + 64);
    `CHK({first, last}, {10'h40, 10'h7F})
    for (int k = 0; k < 5; k++) frame(8, 8, 10'(k * 64));
    for (int k = 0; k < 5; k++) wr(REG_CMD, 32'h2);
    drain(n0 + 320);
    `CHK(last, 10'hFF)
    wr(REG_CMD, 32'h4);
    frame(8, 8, 10'h0);
    wr(REG_CMD, 32'h4);
    wr(REG_CMD, 32'h2);
    drain(n0 + 320);
    wr(REG_CMD, 32'h4);
    wr(REG_CTRL, 32'h15);
    for (int k = 0; k < 5; k++) frame(8, 8, 10'(k * 64));
    pulse_read;
    frame(8, 8, 10'h140);
    pulse_read;
    pulse_read;
    drain(n0 + 448);
    `CHK(last, 10'hFF)
    frame(8, 8, 10'h180);
    pulse_read;
    pulse_read;
    drain(n0 + 576);
    `CHK(last, 10'h17F)
    wr(REG_CTRL, 32'h16);
    wr(REG_CMD, 32'h4);
    repeat (300) @(posedge clk);
    frame(1, 1, 10'h3FF);
    frame(1, 1, 10'h3FF);
    wr(REG_CMD, 32'h2);
    drain(n0 + 580);
    `CHK({first, last}, {10'h0FE, 10'h000})
    wr(REG_TAB_ADDR, 32'h22A7);
    wr(REG_TAB_DATA, 32'h155);
    wr(REG_CTRL, 32'h18);
    frame(1, 1, 10'h2A7); `CHK(last, 10'h155)
    wr(REG_CTRL, 32'h0);
    frame(1, 1, 10'h2A7); `CHK(last, 10'h0A9)
    tally_and_finish;
  end
endmodule
